// ---- include/ggc_pkg.sv ----
// Shared constants and types for the gauge subcommand link and its two ends.
package ggc_pkg;
  // Clock and time base.
  localparam int CLK_NS = 50;
  localparam int NS_PER_MS = 1000000;
  localparam int LINK_HALF_NS = 200;
  localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_NS;
  localparam int TICK_MS = 1000;
  localparam int SUM_WAIT_MS = 250;
  localparam int SOC_PULSE_MS = 165;
  localparam int CCA_DELAY_S = 60;
  localparam int BCAL_CYC = 16;

  // Link frame: read flag, 7-bit location, write byte, then 8 answer bits.
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 16;
  localparam int HDR_RD = 15;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int SY_CLK = 0;
  localparam int SY_FRM = 1;
  localparam int SY_DAT = 2;

  // Byte locations inside the device.
  localparam logic [6:0] LOC_CMD_LO = 7'h00;
  localparam logic [6:0] LOC_CMD_HI = 7'h01;
  localparam logic [6:0] LOC_ALT_LO = 7'h3E;
  localparam logic [6:0] LOC_ALT_HI = 7'h3F;
  localparam logic [6:0] LOC_BUF = 7'h40;
  localparam logic [6:0] LOC_SUM = 7'h60;
  localparam logic [6:0] LOC_LEN = 7'h61;
  localparam int BUF_BYTES = 16;
  localparam int KEY_BYTES = 8;
  localparam logic [7:0] KEY_LEN = 8'h08;

  // Subcommand codes.
  localparam logic [15:0] SC_STATUS = 16'h0000;
  localparam logic [15:0] SC_DEV_TYPE = 16'h0001;
  localparam logic [15:0] SC_FW_REV = 16'h0002;
  localparam logic [15:0] SC_HW_REV = 16'h0003;
  localparam logic [15:0] SC_CODE_SUM = 16'h0004;
  localparam logic [15:0] SC_STATIC_SUM = 16'h0005;
  localparam logic [15:0] SC_CHEMISTRY_IDENTIFIER_QUERY = 16'h0006;
  localparam logic [15:0] SC_LAST_ECHO = 16'h0007;
  localparam logic [15:0] SC_CHEM_SUM = 16'h0008;
  localparam logic [15:0] SC_BOARD_CAL = 16'h0009;
  localparam logic [15:0] SC_CTR_CAL = 16'h000A;
  localparam logic [15:0] SC_CTR_STORE = 16'h000B;
  localparam logic [15:0] SC_REST_V = 16'h000C;
  localparam logic [15:0] SC_PACK_IN = 16'h000D;
  localparam logic [15:0] SC_PACK_OUT = 16'h000E;
  localparam logic [15:0] SC_ALL_SUM = 16'h0010;
  localparam logic [15:0] SC_DS_ARM = 16'h0011;
  localparam logic [15:0] SC_DS_DISARM = 16'h0012;
  localparam logic [15:0] SC_LS_ARM = 16'h0013;
  localparam logic [15:0] SC_LS_DISARM = 16'h0014;
  localparam logic [15:0] SC_PROF_0 = 16'h0015;
  localparam logic [15:0] SC_PROF_1 = 16'h0016;
  localparam logic [15:0] SC_PROF_2 = 16'h0017;
  localparam logic [15:0] SC_PROF_3 = 16'h0018;
  localparam logic [15:0] SC_CAL_FLAG = 16'h002D;
  localparam logic [15:0] SC_LOCK = 16'h0030;
  localparam logic [15:0] SC_KEYS = 16'h0035;
  localparam logic [15:0] SC_RESET = 16'h0041;

  // Signature selectors.
  localparam logic [1:0] SIG_CODE = 2'h0;
  localparam logic [1:0] SIG_STATIC = 2'h1;
  localparam logic [1:0] SIG_CHEM = 2'h2;
  localparam logic [1:0] SIG_ALL = 2'h3;

  // Control status word bit positions; the high byte reads as zero.
  localparam int CS_DSR = 7;
  localparam int CS_CCA = 5;
  localparam int CS_BCA = 4;
  localparam int CS_LSE = 3;
  localparam int CS_PROF = 0;

  // Host register map on AHB-Lite.
  localparam logic [7:0] OFF_XFER = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam int ST_BUSY = 0;
  localparam int ST_RDATA = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    J_IDLE = 3'b001,
    J_SUM = 3'b010,
    J_BCAL = 3'b100
  } ggc_job_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_RUN = 3'b010,
    H_TAIL = 3'b100
  } ggc_hst_type;
endpackage

// ---- include/ggc_link_if.sv ----
// Four-wire framed serial link between the host end and the gauge end.
`timescale 1ns/10ps
`default_nettype none
interface ggc_link_if;
  logic sclk;
  logic frame;
  logic mosi;
  logic miso;
  modport host(output sclk, output frame, output mosi, input miso);
  modport dev(input sclk, input frame, input mosi, output miso);
endinterface
`default_nettype wire

// ---- core/ggc_dev.sv ----
// Gauge end: link slave, subcommand decoder and status logic.
`timescale 1ns/10ps
`default_nettype none
module ggc_dev
  import ggc_pkg::*;
#(
  parameter int TICK_CYC = TICK_MS * (NS_PER_MS / CLK_NS),
  parameter int SUM_WAIT_CYC = SUM_WAIT_MS * (NS_PER_MS / CLK_NS),
  parameter int SOC_PULSE_CYC = SOC_PULSE_MS * (NS_PER_MS / CLK_NS),
  parameter logic [15:0] DEV_TYPE = 16'h5A01, // Arbitrary value.
  parameter logic [15:0] HW_REV = 16'h0011, // Arbitrary value.
  parameter logic [15:0] FW_DEV = 16'h5A01, // Arbitrary value.
  parameter logic [15:0] FW_VER = 16'h0100,
  parameter logic [15:0] FW_BUILD = 16'h0001,
  parameter logic [15:0] FW_TYPE = 16'h0000
)(
  input wire logic mclk,
  input wire logic rst_b,
  ggc_link_if.dev link,
  input wire logic pack_detect_enable,
  input wire logic charge_inhibit,
  input wire logic rest_voltage_pulse_enable,
  input wire logic deep_sleep_ended,
  input wire logic gauge_change,
  input wire logic [15:0] chemistry_identifier_query,
  input wire logic [3:0][15:0] sig_calc,
  input wire logic [3:0][15:0] sig_ref,
  output logic [15:0] control_status_word,
  output logic [1:0] profile_sel,
  output logic deep_sleep_request,
  output logic light_sleep_enable,
  output logic pack_present,
  output logic rest_voltage_failed,
  output logic cal_flag,
  output logic locked_access,
  output logic init_done,
  output logic soc_int,
  output logic ev_board_cal,
  output logic ev_counter_cal,
  output logic ev_counter_store,
  output logic ev_rest_sample,
  output logic ev_full_reset
);
  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic clk_old;
    logic [14:0] sh;
    logic [4:0] bitn;
    logic [7:0] tx;
    logic miso;
    logic [7:0] code_lo;
    logic [15:0] code;
    logic [15:0] prev;
    logic [BUF_BYTES-1:0][7:0] rbuf;
    logic [7:0] rsum;
    logic [7:0] rlen;
    logic [KEY_BYTES-1:0][7:0] keys;
    ggc_job_type job;
    logic [24:0] jcnt;
    logic [1:0] jsel;
    logic [24:0] tcnt;
    logic [6:0] secs;
    logic [21:0] soc_cnt;
    logic soc;
    logic dsr;
    logic lse;
    logic cca;
    logic cca_req;
    logic bca;
    logic calf;
    logic locked;
    logic initd;
    logic packp;
    logic rvf;
    logic rv_pend;
    logic [1:0] prof;
    logic ev_board;
    logic ev_ccm;
    logic ev_ccs;
    logic ev_rv;
    logic ev_rst;
  } ggc_dev_state_type;

  ggc_dev_state_type q;
  ggc_dev_state_type n;
  logic [15:0] csw;

  always_comb begin
    csw = 16'h0000;
    csw[CS_DSR] = q.dsr;
    csw[CS_CCA] = q.cca;
    csw[CS_BCA] = q.bca;
    csw[CS_LSE] = q.lse;
    csw[CS_PROF +: 2] = q.prof;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic rise;
    logic fall;
    logic tick;
    logic wr_en;
    logic [15:0] hdr;
    logic [15:0] cmd;
    logic [15:0] sig;
    logic [7:0] rdv;
    logic [7:0] ksum;
    logic [6:0] loc;
    logic [3:0] idx;
    rise = q.sy2[SY_CLK] & ~q.clk_old;
    fall = ~q.sy2[SY_CLK] & q.clk_old;
    tick = (q.tcnt == 25'(TICK_CYC - 1));
    wr_en = 1'b0;
    hdr = {q.sh, q.sy2[SY_DAT]};
    cmd = {hdr[7:0], q.code_lo};
    loc = hdr[14:8];
    idx = 4'(loc - LOC_BUF);
    sig = sig_calc[q.jsel];
    rdv = 8'h00;
    ksum = SC_KEYS[7:0] + SC_KEYS[15:8];
    for (int i = 0; i < KEY_BYTES; i++) begin
      ksum = ksum + q.rbuf[i];
    end
    n = q;
    n.ev_board = 1'b0;
    n.ev_ccm = 1'b0;
    n.ev_ccs = 1'b0;
    n.ev_rv = 1'b0;
    n.ev_rst = 1'b0;
    n.sy1 = {link.mosi, link.frame, link.sclk};
    n.sy2 = q.sy1;
    n.clk_old = q.sy2[SY_CLK];

    // Background timing runs first so that a command in the same cycle wins.
    n.tcnt = tick ? 25'h0000000 : q.tcnt + 25'h0000001;
    if (deep_sleep_ended) begin
      n.dsr = 1'b0;
    end
    if (q.soc) begin
      if (q.soc_cnt == 22'h000000) begin
        n.soc = 1'b0;
      end else begin
        n.soc_cnt = q.soc_cnt - 22'h000001;
      end
    end
    if (tick) begin
      n.initd = 1'b1;
      if (q.initd && q.secs != 7'(CCA_DELAY_S)) begin
        n.secs = q.secs + 7'h01;
      end
      // Calibration runs for one whole tick each time it is started.
      n.cca = (q.initd && q.secs == 7'(CCA_DELAY_S - 1)) ||
              (q.cca_req && q.secs == 7'(CCA_DELAY_S));
      if (q.secs == 7'(CCA_DELAY_S)) begin
        n.cca_req = 1'b0;
      end
      if (q.rv_pend) begin
        n.rv_pend = 1'b0;
        n.ev_rv = 1'b1;
        if (rest_voltage_pulse_enable) begin
          n.soc = 1'b1;
          n.soc_cnt = 22'(SOC_PULSE_CYC - 1);
        end
      end
    end
    if (gauge_change) begin
      n.cca_req = 1'b1;
    end
    case (q.job)
      J_IDLE: begin
      end
      J_SUM: begin
        if (q.jcnt == 25'h0000000) begin
          n.job = J_IDLE;
          n.rbuf[0] = sig[7:0];
          n.rbuf[1] = {sig != sig_ref[q.jsel], sig[14:8]};
        end else begin
          n.jcnt = q.jcnt - 25'h0000001;
        end
      end
      J_BCAL: begin
        if (q.jcnt == 25'h0000000) begin
          n.job = J_IDLE;
          n.bca = 1'b0;
          n.ev_board = 1'b1;
        end else begin
          n.jcnt = q.jcnt - 25'h0000001;
        end
      end
      default: n.job = J_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////////
    // Link: header bits on rising edges, answer byte out on falling edges.
    case (loc)
      LOC_CMD_LO: rdv = csw[7:0];
      LOC_CMD_HI: rdv = csw[15:8];
      LOC_ALT_LO: rdv = q.code[7:0];
      LOC_ALT_HI: rdv = q.code[15:8];
      LOC_SUM: rdv = q.rsum;
      LOC_LEN: rdv = q.rlen;
      default: begin
        if (loc >= LOC_BUF && loc < 7'(LOC_BUF + BUF_BYTES)) begin
          rdv = q.rbuf[idx];
        end
      end
    endcase
    if (!q.sy2[SY_FRM]) begin
      n.bitn = 5'h00;
    end else if (rise) begin
      n.sh = hdr[14:0];
      n.bitn = q.bitn + 5'h01;
      if (q.bitn == HDR_LAST) begin
        if (hdr[HDR_RD]) begin
          n.tx = rdv;
        end else begin
          wr_en = 1'b1;
        end
      end
    end else if (fall && q.bitn >= 5'(HDR_BITS)) begin
      n.miso = q.tx[7];
      n.tx = {q.tx[6:0], 1'b0};
    end

    if (wr_en) begin
      case (loc)
        LOC_CMD_LO, LOC_ALT_LO: n.code_lo = hdr[7:0];
        LOC_SUM: n.rsum = hdr[7:0];
        LOC_LEN: begin
          n.rlen = hdr[7:0];
          // New keys take only with the right length and a matching checksum.
          if (q.code == SC_KEYS && !q.locked && hdr[7:0] == KEY_LEN &&
              q.rsum == ~ksum) begin
            for (int i = 0; i < KEY_BYTES; i++) begin
              n.keys[i] = q.rbuf[i];
            end
          end
        end
        LOC_CMD_HI, LOC_ALT_HI: begin
          n.prev = q.code;
          n.code = cmd;
          case (cmd)
            SC_STATUS: begin
            end
            SC_DEV_TYPE: begin
              n.rbuf[0] = DEV_TYPE[7:0];
              n.rbuf[1] = DEV_TYPE[15:8];
            end
            SC_FW_REV: begin
              n.rbuf = '0;
              n.rbuf[1:0] = FW_DEV;
              n.rbuf[3:2] = FW_VER;
              n.rbuf[5:4] = FW_BUILD;
              n.rbuf[7:6] = FW_TYPE;
            end
            SC_HW_REV: n.rbuf[1:0] = HW_REV;
            SC_CODE_SUM, SC_STATIC_SUM, SC_CHEM_SUM, SC_ALL_SUM: begin
              n.job = J_SUM;
              n.jcnt = 25'(SUM_WAIT_CYC - 1);
              n.jsel = (cmd == SC_CODE_SUM) ? SIG_CODE :
                       (cmd == SC_STATIC_SUM) ? SIG_STATIC :
                       (cmd == SC_CHEM_SUM) ? SIG_CHEM : SIG_ALL;
            end
            SC_CHEMISTRY_IDENTIFIER_QUERY: n.rbuf[1:0] = chemistry_identifier_query;
            SC_LAST_ECHO: n.rbuf[1:0] = q.code;
            SC_BOARD_CAL: begin
              n.job = J_BCAL;
              n.jcnt = 25'(BCAL_CYC - 1);
              n.bca = 1'b1;
            end
            SC_CTR_CAL: n.ev_ccm = 1'b1;
            SC_CTR_STORE: n.ev_ccs = 1'b1;
            SC_REST_V: begin
              if (charge_inhibit) begin
                n.rvf = 1'b1;
              end else begin
                n.rv_pend = 1'b1;
              end
            end
            SC_PACK_IN: n.packp = pack_detect_enable ? q.packp : 1'b1;
            SC_PACK_OUT: n.packp = pack_detect_enable ? q.packp : 1'b0;
            SC_DS_ARM: n.dsr = 1'b1;
            SC_DS_DISARM: n.dsr = 1'b0;
            SC_LS_ARM: n.lse = 1'b1;
            SC_LS_DISARM: n.lse = 1'b0;
            SC_PROF_0, SC_PROF_1, SC_PROF_2, SC_PROF_3: begin
              n.prof = cmd[1:0] - 2'h1;
            end
            SC_CAL_FLAG: n.calf = q.locked ? q.calf : ~q.calf;
            SC_LOCK: n.locked = 1'b1;
            SC_KEYS: begin
              if (!q.locked) begin
                n.rbuf[KEY_BYTES-1:0] = q.keys;
              end
            end
            SC_RESET: begin
              if (!q.locked) begin
                n.ev_rst = 1'b1;
                n.dsr = 1'b0;
                n.lse = 1'b0;
                n.prof = 2'h0;
                n.calf = 1'b0;
                n.packp = 1'b0;
                n.rvf = 1'b0;
                n.rv_pend = 1'b0;
                n.bca = 1'b0;
                n.cca = 1'b0;
                n.cca_req = 1'b0;
                n.initd = 1'b0;
                n.secs = 7'h00;
                n.tcnt = 25'h0000000;
                n.job = J_IDLE;
              end
            end
            default: begin
            end
          endcase
        end
        default: begin
          if (loc >= LOC_BUF && loc < 7'(LOC_BUF + BUF_BYTES)) begin
            n.rbuf[idx] = hdr[7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.job <= J_IDLE;
    end else begin
      q <= n;
    end
  end

  assign link.miso = q.miso;
  assign control_status_word = csw;
  assign profile_sel = q.prof;
  assign deep_sleep_request = q.dsr;
  assign light_sleep_enable = q.lse;
  assign pack_present = q.packp;
  assign rest_voltage_failed = q.rvf;
  assign cal_flag = q.calf;
  assign locked_access = q.locked;
  assign init_done = q.initd;
  assign soc_int = q.soc;
  assign ev_board_cal = q.ev_board;
  assign ev_counter_cal = q.ev_ccm;
  assign ev_counter_store = q.ev_ccs;
  assign ev_rest_sample = q.ev_rv;
  assign ev_full_reset = q.ev_rst;
endmodule // ggc_dev
`default_nettype wire

// ---- core/ggc_host.sv ----
// Host end: AHB-Lite register slave that runs single-byte frames on the link.
`timescale 1ns/10ps
`default_nettype none
module ggc_host
  import ggc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  ggc_link_if.host link
);
  typedef struct packed {
    logic dp_valid;
    logic dp_wr;
    logic [7:0] dp_off;
    logic [31:0] hrd;
    logic [15:0] xfer;
    logic [7:0] rdata;
    ggc_hst_type st;
    logic [2:0] div;
    logic [4:0] bitn;
    logic [23:0] sh;
    logic [7:0] rx;
    logic sclk;
    logic frame;
    logic mosi;
    logic m1;
    logic m2;
  } ggc_host_state_type;

  ggc_host_state_type q;
  ggc_host_state_type n;

  always_comb begin
    logic take;
    logic busy;
    logic half;
    take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
    busy = (q.st != H_IDLE);
    half = (q.div == 3'(LINK_HALF_CYC - 1));
    n = q;
    n.m1 = link.miso;
    n.m2 = q.m1;
    n.dp_valid = take;
    if (take) begin
      n.dp_wr = hwrite;
      n.dp_off = haddr[7:0];
      n.hrd = 32'h00000000;
      if (haddr[7:0] == OFF_XFER) begin
        n.hrd[15:0] = q.xfer;
      end else if (haddr[7:0] == OFF_STAT) begin
        n.hrd[ST_BUSY] = busy;
        n.hrd[ST_RDATA +: 8] = q.rdata;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Link master: the host makes the link clock from a divider.
    n.div = half ? 3'h0 : q.div + 3'h1;
    case (q.st)
      H_IDLE: n.div = 3'h0;
      H_RUN: begin
        if (half) begin
          if (!q.sclk) begin
            n.sclk = 1'b1;
          end else begin
            // The answer is sampled late in the high half to allow for the
            // device's input synchroniser and ours.
            n.sclk = 1'b0;
            n.rx = {q.rx[6:0], q.m2};
            n.bitn = q.bitn + 5'h01;
            n.sh = {q.sh[22:0], 1'b0};
            if (q.bitn == FRAME_LAST) begin
              n.st = H_TAIL;
            end else begin
              n.mosi = q.sh[22];
            end
          end
        end
      end
      H_TAIL: begin
        if (half) begin
          n.frame = 1'b0;
          n.mosi = 1'b0;
          n.st = H_IDLE;
          n.rdata = q.rx;
        end
      end
      default: n.st = H_IDLE;
    endcase

    // Software sequences codes, keys, checksum and waits one byte at a time;
    // a write while a frame runs is dropped, so it must poll busy first.
    if (q.dp_valid && q.dp_wr && q.dp_off == OFF_XFER && !busy) begin
      n.xfer = hwdata[15:0];
      n.sh = {hwdata[15:0], 8'h00};
      n.mosi = hwdata[HDR_RD];
      n.frame = 1'b1;
      n.sclk = 1'b0;
      n.bitn = 5'h00;
      n.div = 3'h0;
      n.st = H_RUN;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = q.hrd;
  assign link.sclk = q.sclk;
  assign link.frame = q.frame;
  assign link.mosi = q.mosi;
endmodule // ggc_host
`default_nettype wire

// ---- dv/ggc_chk.sv ----
// Timing checks on the framed serial link between the host end and the gauge end.
`timescale 1ns/10ps
`default_nettype none
module ggc_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic frame,
  input wire logic mosi,
  input wire logic miso
);
  logic [4:0] rise_q;
  logic sclk_q;

  // Rising link-clock edges seen in the current frame; cleared between frames.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      rise_q <= !frame ? 5'h00 : rise_q + ((sclk && !sclk_q) ? 5'h01 : 5'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_low4;
    !sclk [*4];
  endsequence
  sequence s_high4;
    sclk [*4];
  endsequence

  chk_idle_clock: assert property (!frame |-> !sclk)
    else $error("link clock moved outside a frame");
  chk_frame_start: assert property ($rose(frame) |-> s_low4 ##1 sclk)
    else $error("first link clock rise misplaced");
  chk_high_half: assert property ($rose(sclk) |-> s_high4 ##1 !sclk)
    else $error("link clock high half wrong");
  chk_low_half: assert property ($fell(sclk) |-> s_low4)
    else $error("link clock low half too short");
  chk_rise_spacing: assert property ($rose(sclk) && rise_q < 5'h17 |-> ##8 $rose(sclk))
    else $error("link clock period wrong");
  chk_rise_framed: assert property ($rose(sclk) |-> frame)
    else $error("link clock rose without frame");
  chk_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  chk_bit_count: assert property ($fell(frame) |-> rise_q == 5'h18)
    else $error("frame did not hold 24 bits");
endmodule // ggc_chk
`default_nettype wire

// ---- dv/ggc_tb_top.sv ----
// Self-checking bench: AHB-Lite master driving the host end, which talks to the gauge end.
`timescale 1ns/10ps
`default_nettype none
module ggc_tb_top;
  import ggc_pkg::*;
  localparam int TICK = 200;
  localparam int SUMW = 50;
  localparam int SOCP = 30;
  localparam logic [15:0] DEVT = 16'h5A01; // Arbitrary value.
  localparam logic [15:0] HWR = 16'h00C3; // Arbitrary value.
  localparam logic [15:0] FWV = 16'h0207; // Arbitrary value.
  logic mclk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic pde = 1'b0, ci = 1'b0, rvpe = 1'b1, dse = 1'b0, gc = 1'b0, dsr_o, lse_o;
  logic [15:0] chemistry_identifier_query = 16'h0, control_status_word;
  logic [3:0][15:0] sig_calc = '0, sig_ref = '0;
  logic [1:0] profile_sel;
  logic pack_present, rest_voltage_failed, cal_flag, locked_access, init_done, soc_int;
  logic ev_board_cal, ev_counter_cal, ev_counter_store, ev_rest_sample, ev_full_reset;
  logic [7:0] seen, b;
  logic [7:0] exp_q[$];
  int err_count = 0, tests_run = 0, n_cal = 0, n_rest = 0, n_soc = 0, n_rst = 0, n_cca = 0;
  event got;

  ggc_link_if link_if();
  ggc_host ggc_host_inst (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .link(link_if));
  ggc_dev #(.TICK_CYC(TICK), .SUM_WAIT_CYC(SUMW), .SOC_PULSE_CYC(SOCP), .DEV_TYPE(DEVT),
    .HW_REV(HWR), .FW_VER(FWV))
    ggc_dev_inst (.mclk, .rst_b, .link(link_if), .pack_detect_enable(pde), .charge_inhibit(ci),
    .rest_voltage_pulse_enable(rvpe), .deep_sleep_ended(dse), .gauge_change(gc), .chemistry_identifier_query,
    .sig_calc, .sig_ref, .control_status_word, .profile_sel, .deep_sleep_request(dsr_o),
    .light_sleep_enable(lse_o), .pack_present, .rest_voltage_failed, .cal_flag, .locked_access,
    .init_done, .soc_int, .ev_board_cal, .ev_counter_cal, .ev_counter_store, .ev_rest_sample,
    .ev_full_reset);
  ggc_chk ggc_chk_inst (.mclk, .rst_b, .sclk(link_if.sclk), .frame(link_if.frame),
    .mosi(link_if.mosi), .miso(link_if.miso));

  always #25 mclk = ~mclk;

  // Counted on the falling edge, so a count never races the edge that launches a pulse.
  always @(negedge mclk) begin
    n_cca += int'(control_status_word[CS_CCA] === 1'b1);
    n_cal += int'(ev_board_cal === 1'b1) + int'(ev_counter_cal === 1'b1);
    n_cal += int'(ev_counter_store === 1'b1);
    n_rest += int'(ev_rest_sample === 1'b1);
    n_soc += int'(soc_int === 1'b1);
    n_rst += int'(ev_full_reset === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One single-word AHB-Lite transfer; called just after a rising edge.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  // One link frame; busy is polled because the frame length is the host's business.
  task automatic xfer(input logic r, input logic [6:0] loc, input logic [7:0] d,
      output logic [7:0] q);
    logic [31:0] v;
    ahb(1'b1, OFF_XFER, {16'h0000, r, loc, d}, v);
    repeat (2) @(posedge mclk);
    do ahb(1'b0, OFF_STAT, 32'h0, v); while (v[ST_BUSY] !== 1'b0);
    q = v[ST_RDATA +: 8];
  endtask

  task automatic sub(input logic [15:0] c);
    xfer(1'b0, LOC_CMD_LO, c[7:0], b);
    xfer(1'b0, LOC_CMD_HI, c[15:8], b);
  endtask

  task automatic exp_w(input logic [6:0] loc, input logic [15:0] e);
    exp_q.push_back(e[7:0]);
    xfer(1'b1, loc, 8'h00, seen);
    ->got;
    @(posedge mclk);
    exp_q.push_back(e[15:8]);
    xfer(1'b1, loc + 7'h01, 8'h00, seen);
    ->got;
  endtask

  always @(got) check("link byte", {8'h00, seen}, {8'h00, exp_q.pop_front()});

  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] w;
    logic [15:0] sc[4];
    logic [7:0] key[KEY_BYTES];
    logic [7:0] ks;
    sc = '{SC_CODE_SUM, SC_STATIC_SUM, SC_CHEM_SUM, SC_ALL_SUM};
    void'($urandom(94));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chemistry_identifier_query <= 16'($urandom);
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      sig_calc[k] <= w;
      sig_ref[k] <= w ^ {k[0], 15'h0000};
    end
    exp_w(LOC_CMD_LO, 16'h0000);
    sub(SC_BOARD_CAL);
    sub(SC_CTR_CAL);
    sub(SC_CTR_STORE);
    repeat (BCAL_CYC + 4) @(posedge mclk);
    check("cal events", 16'(n_cal), 16'h0003);
    for (int k = 0; k < 4; k++) begin
      sub(SC_PROF_0 + 16'(k));
      exp_w(LOC_CMD_LO, 16'(k));
      check("profile", {14'h0, profile_sel}, 16'(k));
    end
    sub(SC_DS_ARM);
    sub(SC_LS_ARM);
    exp_w(LOC_CMD_LO, 16'h008B);
    check("arm pins", {14'h0, dsr_o, lse_o}, 16'h0003);
    dse <= 1'b1;
    @(posedge mclk);
    dse <= 1'b0;
    repeat (3) @(posedge mclk);
    check("sleep end", control_status_word, 16'h000B);
    sub(SC_DS_ARM);
    sub(SC_DS_DISARM);
    sub(SC_LS_DISARM);
    check("disarm", control_status_word, 16'h0003);
    check("disarm pins", {14'h0, dsr_o, lse_o}, 16'h0000);
    sub(16'h00FF);
    check("unknown", control_status_word, 16'h0003);
    sub(SC_LAST_ECHO);
    exp_w(LOC_BUF, 16'h00FF);
    exp_w(LOC_ALT_LO, SC_LAST_ECHO);
    sub(SC_DEV_TYPE);
    exp_w(LOC_BUF, DEVT);
    sub(SC_FW_REV);
    exp_w(LOC_BUF + 7'h02, FWV);
    sub(SC_HW_REV);
    exp_w(LOC_BUF, HWR);
    sub(SC_CHEMISTRY_IDENTIFIER_QUERY);
    exp_w(LOC_BUF, chemistry_identifier_query);
    for (int k = 0; k < 4; k++) begin
      sub(sc[k]);
      repeat (SUMW) @(posedge mclk);
      exp_w(LOC_BUF, {k[0], sig_calc[k][14:0]});
    end
    sub(SC_PACK_IN);
    check("pack in", 16'(pack_present), 16'h0001);
    sub(SC_PACK_OUT);
    check("pack out", 16'(pack_present), 16'h0000);
    pde <= 1'b1;
    sub(SC_PACK_IN);
    check("pack ignored", 16'(pack_present), 16'h0000);
    sub(SC_CAL_FLAG);
    check("cal flag", 16'(cal_flag), 16'h0001);
    sub(SC_CAL_FLAG);
    check("cal flag", 16'(cal_flag), 16'h0000);
    sub(SC_KEYS);
    ks = SC_KEYS[7:0] + SC_KEYS[15:8];
    for (int i = 0; i < KEY_BYTES; i++) begin
      key[i] = 8'($urandom);
      ks += key[i];
      xfer(1'b0, LOC_BUF + 7'(i), key[i], b);
    end
    xfer(1'b0, LOC_SUM, ~ks, b);
    xfer(1'b0, LOC_LEN, KEY_LEN, b);
    sub(SC_KEYS);
    for (int i = 0; i < KEY_BYTES; i += 2) begin
      exp_w(LOC_BUF + 7'(i), {key[i + 1], key[i]});
    end
    // By now far more than sixty ticks have passed since init, so one run is over.
    check("cca first run", 16'(n_cca), 16'(TICK));
    gc <= 1'b1;
    @(posedge mclk);
    gc <= 1'b0;
    repeat (2 * TICK + 4) @(posedge mclk);
    check("cca rerun", 16'(n_cca), 16'(2 * TICK));
    check("init", 16'(init_done), 16'h0001);
    sub(SC_REST_V);
    repeat (TICK + SOCP + 4) @(posedge mclk);
    check("rest sample", 16'(n_rest), 16'h0001);
    check("pulse len", 16'(n_soc), 16'(SOCP));
    ci <= 1'b1;
    sub(SC_REST_V);
    repeat (TICK + 4) @(posedge mclk);
    check("rest fail", 16'(rest_voltage_failed), 16'h0001);
    check("no sample", 16'(n_rest), 16'h0001);
    sub(SC_RESET);
    check("reset", 16'(n_rst), 16'h0001);
    sub(SC_LOCK);
    check("locked", 16'(locked_access), 16'h0001);
    sub(SC_RESET);
    check("reset refused", 16'(n_rst), 16'h0001);
    conclude();
  end
endmodule // ggc_tb_top
`default_nettype wire
